// file: rtl/ast_pkg.sv
// package: constants, enums and carriers of the serial transceiver
package ast_pkg;
  localparam int AST_AW = 5;
  // ==================== register map
  localparam logic [4:0] AST_OFS_MODE = 5'h00;
  localparam logic [4:0] AST_OFS_CTRL = 5'h04;
  localparam logic [4:0] AST_OFS_TXD = 5'h08;
  localparam logic [4:0] AST_OFS_RXD = 5'h0c;
  localparam logic [4:0] AST_OFS_BAUD = 5'h10;
  localparam int AST_CTL_TXEN = 0;
  localparam int AST_CTL_BRK = 1;
  localparam int AST_CTL_ISEL = 2;
  localparam int AST_CTL_OVERRUN_FLAG = 4;
  localparam int AST_STS_RXAV = 8;
  localparam int AST_STS_TXFULL = 9;
  localparam int AST_STS_TRMT = 10;
  localparam logic [15:0] AST_DIV_RST = 16'h0000;
  localparam logic [1:0] AST_RESP_OK = 2'h0;
  localparam logic [1:0] AST_RESP_ERR = 2'h2;
  // ==================== timing
  localparam logic [3:0] AST_OVS_N_M1 = 4'hf;
  localparam logic [3:0] AST_OVS_H_M1 = 4'h3;
  localparam logic [3:0] AST_MID_N = 4'h7;
  localparam logic [3:0] AST_MID_H = 4'h1;
  localparam logic [4:0] AST_SH_N = 5'h04;
  localparam logic [4:0] AST_SH_H = 5'h02;
  localparam logic [3:0] AST_IR_PULSE = 4'h3;
  localparam logic [3:0] AST_IR_HOLD = 4'hf;
  localparam int AST_TXEN_IRQ_DLY = 2;
  // ==================== types
  typedef enum logic [1:0] {
    AST_PD_8N = 2'b00, AST_PD_8E = 2'b01, AST_PD_8O = 2'b10, AST_PD_9N = 2'b11
  } ast_pd_t;
  typedef enum logic [1:0] {
    AST_IS_CHAR = 2'b00, AST_IS_DONE = 2'b01, AST_IS_EMPTY = 2'b10, AST_IS_RSV = 2'b11
  } ast_isel_t;
  typedef enum logic [2:0] {
    AST_TX_IDLE = 3'b000, AST_TX_ARM = 3'b001, AST_TX_START = 3'b010,
    AST_TX_DATA = 3'b011, AST_TX_PAR = 3'b100, AST_TX_STOP = 3'b101
  } ast_txs_t;
  typedef enum logic [2:0] {
    AST_RX_IDLE = 3'b000, AST_RX_START = 3'b001, AST_RX_DATA = 3'b010,
    AST_RX_PAR = 3'b011, AST_RX_STOP = 3'b100
  } ast_rxs_t;
  typedef struct packed {
    logic addr_det;
    logic bclk_out;
    logic flow_en;
    logic ir_en;
    logic loopback;
    logic abaud;
    logic hs_baud;
    ast_pd_t pdsel;
    logic two_stop;
  } ast_mode_t;
  typedef struct packed {
    logic [AST_AW-1:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [AST_AW-1:0] araddr;
    logic arvalid;
    logic rready;
  } ast_axi_req_t;
  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } ast_axi_rsp_t;
endpackage : ast_pkg

// file: rtl/ast_uart.sv
// design: full-duplex serial transceiver with register slave
`timescale 1ns/10ps
`default_nettype none
module ast_uart import ast_pkg::*; #(
  parameter int DEPTH = 4
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire ast_axi_req_t axi_req,
  output wire ast_axi_rsp_t axi_rsp,
  input wire logic serial_in_pin,
  output wire logic serial_out_pin,
  input wire logic clear_to_send_n,
  output wire logic request_to_send_n,
  output wire logic tx_irq
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL = (PW+1)'(DEPTH);
  localparam logic [PW:0] CNT1 = (PW+1)'(1);
  localparam logic [PW-1:0] PTR1 = PW'(1);

  typedef struct packed {
    logic [1:0] rxs;
    logic [1:0] ctss;
    logic aw_h;
    logic w_h;
    logic [AST_AW-1:0] awa;
    logic [31:0] wd;
    logic [3:0] ws;
    ast_axi_rsp_t bus;
    ast_mode_t mode;
    logic [15:0] div;
    logic txen;
    logic brk;
    logic overrun_flag;
    ast_isel_t isel;
    logic [15:0] bcnt;
    logic [AST_TXEN_IRQ_DLY-1:0] txen_dly;
    logic [DEPTH-1:0][8:0] tq;
    logic [PW-1:0] twp;
    logic [PW-1:0] trp;
    logic [PW:0] tcnt;
    logic [DEPTH-1:0][10:0] rq;
    logic [PW-1:0] rwp;
    logic [PW-1:0] rrp;
    logic [PW:0] rcnt;
    ast_txs_t txs;
    logic [3:0] tsub;
    logic [3:0] tbit;
    logic [8:0] tx_shift_reg;
    logic tpar;
    logic tbrk;
    logic tline;
    ast_rxs_t rxst;
    logic [3:0] rsub;
    logic [3:0] rbit;
    logic [8:0] rsr;
    logic rpe;
    logic rprev;
    logic [3:0] irh;
    logic ab_act;
    logic [19:0] abcnt;
    logic tx_pin;
    logic rts_n;
    logic tx_irq;
  } ast_st_t;

  ast_st_t st_r;
  ast_st_t st_nxt;
  logic [1:0] rsync_r;
  logic rst_q_n;
  logic hs, nine, par_on, ir_on, tick, tbend, rbend, rin, wr, rd;
  logic tpush, tpop, rpush, rpop, rdrop, clr;
  logic [3:0] ovs_m1;
  logic [3:0] nd_m1;
  logic [3:0] mid;
  logic [8:0] rd9;
  logic [19:0] abq;

  // ==================== reset release
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rsync_r <= 2'h0;
    end else begin
      rsync_r <= {rsync_r[0], 1'b1};
    end
  end
  assign rst_q_n = rsync_r[1];

  // ==================== next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.tx_irq = 1'b0;
    st_nxt.rxs = {st_r.rxs[0], serial_in_pin};
    st_nxt.ctss = {st_r.ctss[0], clear_to_send_n};
    hs = st_r.mode.hs_baud;
    ovs_m1 = hs ? AST_OVS_H_M1 : AST_OVS_N_M1;
    mid = hs ? AST_MID_H : AST_MID_N;
    nine = st_r.mode.pdsel == AST_PD_9N;
    nd_m1 = nine ? 4'h8 : 4'h7;
    par_on = st_r.mode.pdsel == AST_PD_8E || st_r.mode.pdsel == AST_PD_8O;
    ir_on = st_r.mode.ir_en && !hs;
    tick = st_r.bcnt == st_r.div;
    tbend = tick && st_r.tsub == ovs_m1;
    rbend = tick && st_r.rsub == ovs_m1;
    rin = st_r.mode.loopback ? st_r.tline : (ir_on ? st_r.irh == 4'h0 : st_r.rxs[1]);
    wr = st_r.aw_h && st_r.w_h && !st_r.bus.bvalid;
    rd = axi_req.arvalid && st_r.bus.arready;
    tpush = 1'b0;
    tpop = 1'b0;
    rpush = 1'b0;
    rpop = 1'b0;
    rdrop = 1'b0;
    clr = 1'b0;
    rd9 = 9'h000;
    abq = 20'h00000;
    st_nxt.bcnt = tick ? 16'h0000 : st_r.bcnt + 16'h0001;

    // ==================== bus write
    if (axi_req.awvalid && st_r.bus.awready) begin
      st_nxt.aw_h = 1'b1;
      st_nxt.awa = axi_req.awaddr;
    end
    if (axi_req.wvalid && st_r.bus.wready) begin
      st_nxt.w_h = 1'b1;
      st_nxt.wd = axi_req.wdata;
      st_nxt.ws = axi_req.wstrb;
    end
    if (st_r.bus.bvalid && axi_req.bready) begin
      st_nxt.bus.bvalid = 1'b0;
    end
    if (wr) begin
      st_nxt.aw_h = 1'b0;
      st_nxt.w_h = 1'b0;
      st_nxt.bus.bvalid = 1'b1;
      st_nxt.bus.bresp = AST_RESP_OK;
      case (st_r.awa)
        AST_OFS_MODE: st_nxt.mode = ast_mode_t'(st_r.wd[9:0]);
        AST_OFS_CTRL: begin
          if (st_r.wd[AST_CTL_TXEN] && !st_r.txen) begin
            clr = 1'b1;
          end
          st_nxt.txen = st_r.wd[AST_CTL_TXEN];
          st_nxt.brk = st_r.wd[AST_CTL_BRK];
          st_nxt.isel = ast_isel_t'(st_r.wd[AST_CTL_ISEL+:2]);
          if (!st_r.wd[AST_CTL_OVERRUN_FLAG]) begin
            st_nxt.overrun_flag = 1'b0;
          end
        end
        AST_OFS_TXD: begin
          if ((nine ? &st_r.ws[1:0] : st_r.ws[0]) && st_r.tcnt != FULL) begin
            st_nxt.tq[st_r.twp] = nine ? st_r.wd[8:0] : {1'b0, st_r.wd[7:0]};
            st_nxt.twp = st_r.twp + PTR1;
            tpush = 1'b1;
          end
        end
        AST_OFS_BAUD: begin
          st_nxt.div = st_r.wd[15:0];
          clr = 1'b1;
        end
        default: st_nxt.bus.bresp = AST_RESP_ERR;
      endcase
    end
    st_nxt.bus.awready = !st_nxt.aw_h && !st_nxt.bus.bvalid;
    st_nxt.bus.wready = !st_nxt.w_h && !st_nxt.bus.bvalid;

    // ==================== bus read
    if (st_r.bus.rvalid && axi_req.rready) begin
      st_nxt.bus.rvalid = 1'b0;
    end
    if (rd) begin
      st_nxt.bus.rvalid = 1'b1;
      st_nxt.bus.rresp = AST_RESP_OK;
      st_nxt.bus.rdata = 32'h00000000;
      case (axi_req.araddr)
        AST_OFS_MODE: st_nxt.bus.rdata[9:0] = st_r.mode;
        AST_OFS_CTRL: begin
          st_nxt.bus.rdata[AST_CTL_TXEN] = st_r.txen;
          st_nxt.bus.rdata[AST_CTL_BRK] = st_r.brk;
          st_nxt.bus.rdata[AST_CTL_ISEL+:2] = st_r.isel;
          st_nxt.bus.rdata[AST_CTL_OVERRUN_FLAG] = st_r.overrun_flag;
          st_nxt.bus.rdata[AST_STS_RXAV] = st_r.rcnt != '0;
          st_nxt.bus.rdata[AST_STS_TXFULL] = st_r.tcnt == FULL;
          st_nxt.bus.rdata[AST_STS_TRMT] = st_r.tcnt == '0 && st_r.txs == AST_TX_IDLE;
        end
        AST_OFS_TXD: st_nxt.bus.rdata = 32'h00000000;
        AST_OFS_RXD: begin
          if (st_r.rcnt != '0) begin
            st_nxt.bus.rdata[10:0] = st_r.rq[st_r.rrp];
            st_nxt.rrp = st_r.rrp + PTR1;
            rpop = 1'b1;
          end
        end
        AST_OFS_BAUD: st_nxt.bus.rdata[15:0] = st_r.div;
        default: st_nxt.bus.rresp = AST_RESP_ERR;
      endcase
    end
    st_nxt.bus.arready = !st_nxt.bus.rvalid;
    if (clr) begin
      st_nxt.bcnt = 16'h0000;
    end

    st_nxt.txen_dly = {st_r.txen_dly[AST_TXEN_IRQ_DLY-2:0], !st_r.txen && st_nxt.txen};
    if (st_r.txen_dly[AST_TXEN_IRQ_DLY-1]) begin
      st_nxt.tx_irq = 1'b1;
    end

    // ==================== transmitter
    if (st_r.txs == AST_TX_IDLE || st_r.txs == AST_TX_ARM) begin
      st_nxt.tsub = 4'h0;
    end else if (tick) begin
      st_nxt.tsub = st_r.tsub == ovs_m1 ? 4'h0 : st_r.tsub + 4'h1;
    end
    unique case (st_r.txs)
      AST_TX_IDLE: begin
        if (st_r.txen && st_r.tcnt != '0 && !(st_r.mode.flow_en && st_r.ctss[1])) begin
          tpop = 1'b1;
          st_nxt.tx_shift_reg = st_r.tq[st_r.trp];
          st_nxt.trp = st_r.trp + PTR1;
          st_nxt.tbrk = st_r.brk;
          st_nxt.tpar = st_r.mode.pdsel == AST_PD_8O;
          st_nxt.txs = AST_TX_ARM;
          if (st_r.isel == AST_IS_CHAR || st_r.isel == AST_IS_RSV ||
              (st_r.isel == AST_IS_EMPTY && st_r.tcnt == CNT1)) begin
            st_nxt.tx_irq = 1'b1;
          end
        end
      end
      AST_TX_ARM: begin
        if (tick) begin
          st_nxt.txs = AST_TX_START;
        end
      end
      AST_TX_START: begin
        if (tbend) begin
          st_nxt.txs = AST_TX_DATA;
          st_nxt.tbit = 4'h0;
        end
      end
      AST_TX_DATA: begin
        if (tbend) begin
          st_nxt.tx_shift_reg = st_r.tx_shift_reg >> 1;
          st_nxt.tpar = st_r.tpar ^ st_r.tx_shift_reg[0];
          st_nxt.tbit = st_r.tbit + 4'h1;
          if (st_r.tbit == nd_m1) begin
            st_nxt.txs = par_on ? AST_TX_PAR : AST_TX_STOP;
            st_nxt.tbit = 4'h0;
          end
        end
      end
      AST_TX_PAR: begin
        if (tbend) begin
          st_nxt.txs = AST_TX_STOP;
        end
      end
      AST_TX_STOP: begin
        if (tbend) begin
          if (st_r.mode.two_stop && st_r.tbit == 4'h0) begin
            st_nxt.tbit = 4'h1;
          end else begin
            st_nxt.txs = AST_TX_IDLE;
            if (st_r.tbrk) begin
              st_nxt.brk = 1'b0;
              st_nxt.tbrk = 1'b0;
            end
            if (st_r.isel == AST_IS_DONE && st_r.tcnt == '0) begin
              st_nxt.tx_irq = 1'b1;
            end
          end
        end
      end
      default: st_nxt.txs = AST_TX_IDLE;
    endcase
    unique case (st_nxt.txs)
      AST_TX_START: st_nxt.tline = 1'b0;
      AST_TX_DATA: st_nxt.tline = !st_nxt.tbrk && st_nxt.tx_shift_reg[0];
      AST_TX_PAR: st_nxt.tline = !st_nxt.tbrk && st_nxt.tpar;
      default: st_nxt.tline = 1'b1;
    endcase
    if (st_r.mode.loopback) begin
      st_nxt.tx_pin = 1'b1;
    end else if (ir_on) begin
      st_nxt.tx_pin = !st_nxt.tline && st_nxt.tsub < AST_IR_PULSE;
    end else begin
      st_nxt.tx_pin = st_nxt.tline;
    end

    // ==================== receiver
    st_nxt.rprev = rin;
    if (ir_on && st_r.rxs[1]) begin
      st_nxt.irh = AST_IR_HOLD;
    end else if (tick && st_r.irh != 4'h0) begin
      st_nxt.irh = st_r.irh - 4'h1;
    end
    if (tick) begin
      st_nxt.rsub = st_r.rsub == ovs_m1 ? 4'h0 : st_r.rsub + 4'h1;
    end
    unique case (st_r.rxst)
      AST_RX_IDLE: begin
        if (!rin && !st_r.mode.abaud) begin
          st_nxt.rxst = AST_RX_START;
          st_nxt.rsub = 4'h0;
        end
      end
      AST_RX_START: begin
        if (tick && st_r.rsub == mid) begin
          st_nxt.rxst = rin ? AST_RX_IDLE : AST_RX_DATA;
          st_nxt.rsub = 4'h0;
          st_nxt.rbit = 4'h0;
          st_nxt.rpe = st_r.mode.pdsel == AST_PD_8O;
        end
      end
      AST_RX_DATA: begin
        if (rbend) begin
          st_nxt.rsr = {rin, st_r.rsr[8:1]};
          st_nxt.rpe = st_r.rpe ^ rin;
          st_nxt.rbit = st_r.rbit + 4'h1;
          if (st_r.rbit == nd_m1) begin
            st_nxt.rxst = par_on ? AST_RX_PAR : AST_RX_STOP;
          end
        end
      end
      AST_RX_PAR: begin
        if (rbend) begin
          st_nxt.rpe = st_r.rpe ^ rin;
          st_nxt.rxst = AST_RX_STOP;
        end
      end
      AST_RX_STOP: begin
        if (rbend) begin
          st_nxt.rxst = AST_RX_IDLE;
          rd9 = nine ? st_r.rsr : {1'b0, st_r.rsr[8:1]};
          if (!(st_r.mode.addr_det && nine && !rd9[8])) begin
            if (st_r.rcnt == FULL) begin
              st_nxt.overrun_flag = 1'b1;
              rdrop = 1'b1;
            end else begin
              st_nxt.rq[st_r.rwp] = {!rin, par_on && st_r.rpe, rd9};
              st_nxt.rwp = st_r.rwp + PTR1;
              rpush = 1'b1;
            end
          end
        end
      end
      default: st_nxt.rxst = AST_RX_IDLE;
    endcase

    if (st_r.mode.abaud) begin
      if (!st_r.ab_act && st_r.rprev && !rin) begin
        st_nxt.ab_act = 1'b1;
        st_nxt.abcnt = 20'h00000;
      end else if (st_r.ab_act) begin
        st_nxt.abcnt = st_r.abcnt + 20'h00001;
        if (rin) begin
          // low time is one cycle longer than the count
          abq = (st_r.abcnt + 20'h00001) >> (hs ? AST_SH_H : AST_SH_N);
          st_nxt.div = abq[15:0] - 16'h0001;
          st_nxt.mode.abaud = 1'b0;
          st_nxt.ab_act = 1'b0;
          st_nxt.bcnt = 16'h0000;
        end
      end
    end

    if (tpush && !tpop) begin
      st_nxt.tcnt = st_r.tcnt + CNT1;
    end else if (tpop && !tpush) begin
      st_nxt.tcnt = st_r.tcnt - CNT1;
    end
    if (rpush && !rpop) begin
      st_nxt.rcnt = st_r.rcnt + CNT1;
    end else if (rpop && !rpush) begin
      st_nxt.rcnt = st_r.rcnt - CNT1;
    end
    if (st_r.mode.bclk_out) begin
      st_nxt.rts_n = st_r.bcnt > (st_r.div >> 1);
    end else begin
      st_nxt.rts_n = st_r.mode.flow_en ? st_nxt.rcnt == FULL : 1'b1;
    end
  end

  // ==================== state register
  always_ff @(posedge clock or negedge rst_q_n) begin
    if (!rst_q_n) begin
      st_r <= '0;
      st_r.div <= AST_DIV_RST;
      st_r.rxs <= 2'h3;
      st_r.tline <= 1'b1;
      st_r.tx_pin <= 1'b1;
      st_r.rts_n <= 1'b1;
      st_r.rprev <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign axi_rsp = st_r.bus;
  assign serial_out_pin = st_r.tx_pin;
  assign request_to_send_n = st_r.rts_n;
  assign tx_irq = st_r.tx_irq;

  // ==================== checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_q_n);
  timer_wrap_a: assert property (st_r.bcnt <= st_r.div) else $error("baud timer past divisor");
  rate_norm_a: assert property ((st_r.txs == AST_TX_DATA && !hs && $changed(st_r.tbit))
    |-> $past(st_r.tsub) == AST_OVS_N_M1) else $error("normal bit not 16 ticks");
  rate_high_a: assert property ((st_r.txs == AST_TX_DATA && hs && $changed(st_r.tbit))
    |-> $past(st_r.tsub) == AST_OVS_H_M1) else $error("fast bit not 4 ticks");
  baud_clear_a: assert property ((wr && st_r.awa == AST_OFS_BAUD) |=> st_r.bcnt == 16'h0000)
    else $error("divisor write did not clear timer");
  txen_irq_a: assert property ($rose(st_r.txen) |-> ##2 st_r.tx_irq)
    else $error("no interrupt after enable");
  start_low_a: assert property (st_r.txs == AST_TX_START |-> !st_r.tline)
    else $error("start bit not low");
  cts_hold_a: assert property ((st_r.txs == AST_TX_IDLE && st_r.mode.flow_en && st_r.ctss[1])
    |=> st_r.txs == AST_TX_IDLE) else $error("sent without clear to send");
  overrun_a: assert property (rdrop |=> st_r.overrun_flag) else $error("overrun not flagged");
  break_clear_a: assert property ($fell(st_r.tbrk) |-> !st_r.brk)
    else $error("break request not cleared");
  fifo_bound_a: assert property (st_r.tcnt <= FULL && st_r.rcnt <= FULL)
    else $error("queue count beyond depth");
  cover property (st_r.txs == AST_TX_START);
  cover property (rpush);
  cover property ($fell(st_r.mode.abaud));
endmodule : ast_uart
`default_nettype wire

// file: test/ast_remote.sv
// model: remote serial device on the far side of the line
`timescale 1ns/10ps
`default_nettype none
module ast_remote (
  input wire logic clock,
  input wire logic [7:0] bit_clks,
  input wire logic line_in,
  output logic line_out,
  output logic cts_n,
  output logic [7:0] got_byte,
  output logic [7:0] got_cnt
);
  logic [7:0] b;
  // ==================== idle levels
  initial begin
    line_out = 1'b1;
    // clear-to-send starts asserted; set_cts can withhold it
    cts_n = 1'b0;
    got_byte = 8'h00;
    got_cnt = 8'h00;
  end
  // ==================== capture of device frames
  // start low, data lsb first, sampled mid-bit
  always begin
    @(negedge line_in);
    repeat (bit_clks / 2) @(posedge clock);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_clks) @(posedge clock);
      b[i] = line_in;
    end
    // wait to the middle of the stop bit so a low last data bit is not taken as a start
    repeat (bit_clks) @(posedge clock);
    got_byte <= b;
    got_cnt <= got_cnt + 8'h01;
  end
  // frames toward the device; a low stop is only for error tests
  task automatic send(input logic [7:0] v, input logic stop);
    logic [9:0] f;
    f = {stop, v, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clock);
      line_out <= f[i];
      repeat (bit_clks - 8'd1) @(posedge clock);
    end
    @(posedge clock);
    line_out <= 1'b1;
  endtask : send
  // far side withholds or grants clear-to-send
  task automatic set_cts(input logic v);
    @(posedge clock);
    cts_n <= v;
  endtask : set_cts
endmodule : ast_remote
`default_nettype wire

// file: test/testbench.sv
// bench: register-level tests of the serial transceiver
`timescale 1ns/10ps
`default_nettype none
module testbench import ast_pkg::*;;
  logic clock;
  logic rst_n;
  ast_axi_req_t req;
  ast_axi_rsp_t rsp;
  logic line_rx;
  logic line_tx;
  logic cts_n;
  logic rts_n;
  logic tx_irq;
  logic [7:0] got_byte;
  logic [7:0] rcnt;
  logic [7:0] bit_clks;
  logic [31:0] d;
  logic [1:0] rr;
  int irq_cnt = 0;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  ast_uart #(.DEPTH(4)) u_ast_uart (.clock(clock), .rst_n(rst_n), .axi_req(req),
    .axi_rsp(rsp), .serial_in_pin(line_rx), .serial_out_pin(line_tx),
    .clear_to_send_n(cts_n), .request_to_send_n(rts_n), .tx_irq(tx_irq));
  ast_remote u_ast_remote (.clock(clock), .bit_clks(bit_clks), .line_in(line_tx),
    .line_out(line_rx), .cts_n(cts_n), .got_byte(got_byte), .got_cnt(rcnt));
  // ==================== clock, watchdog, interrupt counter
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    irq_cnt <= irq_cnt + int'(tx_irq === 1'b1);
    if (cyc == 20000) begin
      error_cnt++;
      $display("mismatch at %0t: timeout", $time);
      wrap_up();
    end
  end
  // ==================== bus tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    @(posedge clock);
    req.awaddr <= a;
    req.wdata <= v;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do begin
      @(posedge clock);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    req.bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a);
    @(posedge clock);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(posedge clock);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    d = rsp.rdata;
    rr = rsp.rresp;
    req.rready <= 1'b0;
  endtask : rd
  task automatic rdc(input logic [4:0] a, input logic [31:0] exp);
    rd(a);
    check(d, exp);
  endtask : rdc
  task automatic poll(input int bitn);
    repeat (600) begin
      rd(AST_OFS_CTRL);
      if (d[bitn] === 1'b1) break;
    end
  endtask : poll
  task automatic wait_frame();
    logic [7:0] n;
    n = rcnt;
    repeat (800) begin
      @(posedge clock);
      if (rcnt !== n) break;
    end
  endtask : wait_frame
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  // ==================== tests
  initial begin
    int n;
    logic lvl;
    req = '0;
    req.wstrb = 4'hf;
    rst_n = 1'b0;
    bit_clks = 8'd16;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    rdc(AST_OFS_MODE, 32'h0);
    rdc(AST_OFS_CTRL, 32'h400);
    rd(5'h14);
    check({30'h0, rr}, {30'h0, AST_RESP_ERR});
    check(d, 32'h0);
    wr(AST_OFS_BAUD, 32'h1234);
    rdc(AST_OFS_BAUD, 32'h1234);
    // divisor 0 keeps every frame short: one tick per clock
    wr(AST_OFS_BAUD, 32'h0);
    $display("test registers done");
    n = irq_cnt;
    wr(AST_OFS_CTRL, 32'h1);
    repeat (4) @(posedge clock);
    check(irq_cnt - n, 1);
    wr(AST_OFS_TXD, 32'ha5);
    wait_frame();
    check(got_byte, 8'ha5);
    check(irq_cnt - n, 2);
    wr(AST_OFS_MODE, 32'h8);
    bit_clks <= 8'd4;
    wr(AST_OFS_TXD, 32'h3c);
    wait_frame();
    check(got_byte, 8'h3c);
    wr(AST_OFS_MODE, 32'h0);
    bit_clks <= 8'd16;
    $display("test transmit done");
    wr(AST_OFS_CTRL, 32'h3);
    wr(AST_OFS_TXD, 32'hff);
    wr(AST_OFS_TXD, 32'h55);
    wait_frame();
    check(got_byte, 8'h00);
    wait_frame();
    check(got_byte, 8'h55);
    // stop bit still runs when the remote has its byte
    poll(AST_STS_TRMT);
    rdc(AST_OFS_CTRL, 32'h401);
    $display("test break done");
    u_ast_remote.send(8'h96, 1'b1);
    poll(AST_STS_RXAV);
    rdc(AST_OFS_RXD, 32'h96);
    u_ast_remote.send(8'h5a, 1'b0);
    poll(AST_STS_RXAV);
    rdc(AST_OFS_RXD, 32'h45a);
    $display("test receive done");
    wr(AST_OFS_MODE, 32'h22);
    wr(AST_OFS_TXD, 32'h81);
    poll(AST_STS_RXAV);
    rdc(AST_OFS_RXD, 32'h81);
    wr(AST_OFS_MODE, 32'h226);
    wr(AST_OFS_TXD, 32'h55);
    wr(AST_OFS_TXD, 32'h1aa);
    poll(AST_STS_RXAV);
    rdc(AST_OFS_RXD, 32'h1aa);
    wr(AST_OFS_MODE, 32'h25);
    wr(AST_OFS_TXD, 32'h81);
    poll(AST_STS_RXAV);
    rdc(AST_OFS_RXD, 32'h81);
    // a single stop bit would already be idle here
    repeat (10) @(posedge clock);
    rdc(AST_OFS_CTRL, 32'h1);
    $display("test loopback done");
    wr(AST_OFS_MODE, 32'h20);
    for (int i = 0; i < 5; i++) wr(AST_OFS_TXD, 32'h10 + i);
    poll(AST_CTL_OVERRUN_FLAG);
    check(d[AST_CTL_OVERRUN_FLAG], 1'b1);
    rdc(AST_OFS_RXD, 32'h10);
    wr(AST_OFS_CTRL, 32'h1);
    rd(AST_OFS_CTRL);
    check(d[AST_CTL_OVERRUN_FLAG], 1'b0);
    $display("test overrun done");
    // flow control with three entries still queued
    wr(AST_OFS_MODE, 32'ha0);
    repeat (2) @(posedge clock);
    check(rts_n, 1'b0);
    u_ast_remote.set_cts(1'b1);
    wr(AST_OFS_CTRL, 32'h5);
    n = irq_cnt;
    wr(AST_OFS_TXD, 32'h77);
    repeat (40) @(posedge clock);
    rdc(AST_OFS_CTRL, 32'h105);
    u_ast_remote.set_cts(1'b0);
    poll(AST_STS_TRMT);
    check(rts_n, 1'b1);
    check(irq_cnt - n, 1);
    // empty point: middle pop raises nothing
    wr(AST_OFS_CTRL, 32'h9);
    n = irq_cnt;
    for (int i = 0; i < 3; i++) wr(AST_OFS_TXD, 32'h20 + i);
    poll(AST_STS_TRMT);
    check(irq_cnt - n, 2);
    $display("test flow done");
    // 16x clock toggles twice each timer period
    wr(AST_OFS_BAUD, 32'h1);
    wr(AST_OFS_MODE, 32'h100);
    repeat (2) @(posedge clock);
    lvl = rts_n;
    @(posedge clock);
    check(rts_n, !lvl);
    // sync start bit is sixteen clocks long
    wr(AST_OFS_BAUD, 32'h5);
    wr(AST_OFS_MODE, 32'h10);
    u_ast_remote.send(8'h55, 1'b1);
    rdc(AST_OFS_BAUD, 32'h0);
    rdc(AST_OFS_MODE, 32'h0);
    $display("test clock and autobaud done");
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
